// ==== rtl/cstr_router.sv ====
// How it works
// - Trigger input taken from previous or next neighbour, per channel setting.
// - Selected trigger-out is driven toward the neighbour opposite the input.
// - End channel can feed its trigger-out back to the start channel.
// - Trigger-out source: waveform end, position marker, sequence sync, burst done.
// - Slave channels follow the master's frequency word.
// - Each channel adds its own phase offset to the shared phase.
// - Sample tick chosen from master clock, system clock or external arb clock.
// - Offset steps 0.1 degree, or one point when points are coarser.
// - Sync output picks one of seven sources.
// - Standard waveform sync: square wave, high from 0 to 180 degrees.
// - Arbitrary waveform sync: pulse over the first few sample addresses.
// - Marker selection copies the stored per-sample marker bit.
// - Burst done: low while waveform active in gated or triggered mode.
// - Sequence sync: low during last cycle of last waveform.
// - Trigger selection: positive copy of the active trigger.
// - Sweep sync high from sweep start through the first step.
// - Optional marker pulse at one chosen sweep step.
// - Phase lock: rising edge at start of each waveform cycle.
`timescale 1ns/10ps
`default_nettype none
module cstr_router
  import cstr_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // Register port
  input wire logic [3:0] addr_i,
  input wire logic [31:0] wr_data_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rd_data_o,
  // Neighbour trigger pins
  input wire logic prev_trig_i,
  input wire logic next_trig_i,
  input wire logic loop_trig_i,
  output logic trig_to_next_o,
  output logic trig_to_prev_o,
  output logic loop_trig_o,
  // Clock sources
  input wire logic master_tick_i,
  input wire logic sys_tick_i,
  input wire logic ext_clk_i,
  output logic [1:0] clk_sel_o,
  // Master lock
  input wire logic [31:0] master_freq_i,
  output logic [31:0] freq_o,
  output logic [31:0] phase_o,
  // Waveform engine events
  input wire logic marker_i,
  input wire logic seq_last_i,
  input wire logic burst_mode_i,
  input wire logic burst_active_i,
  input wire logic int_trig_i,
  input wire logic sweep_start_i,
  input wire logic sweep_step_i,
  input wire logic [11:0] sweep_idx_i,
  // Sync outputs
  output logic sync_o,
  output logic sweep_mark_o
);

  // ----------------------------------------
  // Decoders
  // ----------------------------------------
  function automatic logic tout_pick(input logic [1:0] s, input logic [3:0] ev);
    tout_pick = ev[s];
  endfunction

  function automatic logic [31:0] pt_mask(input logic [4:0] k);
    if (k >= PTS_FINE)
      pt_mask = 32'hffff_ffff;
    else
      pt_mask = ~(32'hffff_ffff >> k);
  endfunction

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [3:0] pin_w;
  logic [3:0] s1_r;
  logic [3:0] s2_r;
  assign pin_w = {ext_clk_i, loop_trig_i, next_trig_i, prev_trig_i};

  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_sync
      always_ff @(posedge sys_clk_i or negedge rst_n_i)
      begin
        if (!rst_n_i)
        begin
          s1_r[g] <= 1'b0;
          s2_r[g] <= 1'b0;
        end
        else
        begin
          s1_r[g] <= pin_w[g];
          s2_r[g] <= s1_r[g];
        end
      end
    end
  endgenerate

  logic ext_d_r;
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      ext_d_r <= 1'b0;
    else
      ext_d_r <= s2_r[3];
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [C_WIDTH-1:0] ctrl_r;
  logic [11:0] phase_r;
  logic [31:0] freq_r;
  logic [4:0] pts_r;
  logic [11:0] swmk_r;

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ctrl_r <= CTRL_RST;
      phase_r <= PHASE_RST;
      freq_r <= FREQ_RST;
      pts_r <= PTS_RST;
      swmk_r <= SWMK_RST;
    end
    else if (wr_i)
    begin
      case (addr_i)
        A_CTRL: ctrl_r <= wr_data_i[C_WIDTH-1:0];
        // Offsets at or past a full turn are refused
        A_PHASE:
        begin
          if (wr_data_i[11:0] < PH_TENTHS_FULL)
            phase_r <= wr_data_i[11:0];
        end
        A_FREQ: freq_r <= wr_data_i;
        A_PTS: pts_r <= wr_data_i[4:0];
        A_SWMK: swmk_r <= wr_data_i[11:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // Sample tick and phase
  // ----------------------------------------
  logic tick_w;
  logic [1:0] clk_sel_w;
  assign clk_sel_w = ctrl_r[C_CLK_LO +: 2];
  assign clk_sel_o = clk_sel_w;

  always_comb
  begin
    case (clk_sel_w)
      K_MASTER: tick_w = master_tick_i;
      K_SYS: tick_w = sys_tick_i;
      K_EXT: tick_w = s2_r[3] & ~ext_d_r;
      default: tick_w = sys_tick_i;
    endcase
  end

  logic [31:0] freq_w;
  assign freq_w = ctrl_r[C_SLAVE] ? master_freq_i : freq_r;
  assign freq_o = freq_w;

  logic [31:0] acc_r;
  logic [32:0] sum_w;
  logic wrap_r;
  assign sum_w = {1'b0, acc_r} + {1'b0, freq_w};

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      acc_r <= 32'h0000_0000;
      wrap_r <= 1'b0;
    end
    else if (tick_w)
    begin
      acc_r <= sum_w[31:0];
      wrap_r <= sum_w[32];
    end
    else
      wrap_r <= 1'b0;
  end

  // Coarse point tables lose resolution below one point
  logic [43:0] off_full_w;
  logic [31:0] off_w;
  logic [31:0] ph_w;
  assign off_full_w = {32'h0000_0000, phase_r} * {12'h000, PH_PER_TENTH};
  // Synthesised waves keep full 0.1 degree steps
  assign off_w = ctrl_r[C_ARB] ? (off_full_w[31:0] & pt_mask(pts_r)) : off_full_w[31:0];
  assign ph_w = acc_r + off_w;
  assign phase_o = ph_w;

  // ----------------------------------------
  // Selection shadows
  // ----------------------------------------
  // Switching only on a tick keeps mid-sample changes off the pins
  logic [2:0] sync_act_r;
  logic [1:0] tout_act_r;
  logic arb_act_r;
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sync_act_r <= S_WAVE;
      tout_act_r <= T_WEND;
      arb_act_r <= 1'b0;
    end
    else if (tick_w)
    begin
      sync_act_r <= ctrl_r[C_SYNC_LO +: 3];
      tout_act_r <= ctrl_r[C_TOUT_LO +: 2];
      arb_act_r <= ctrl_r[C_ARB];
    end
  end

  // ----------------------------------------
  // Trigger chain
  // ----------------------------------------
  logic trig_in_w;
  assign trig_in_w = ctrl_r[C_LOOP_START] ? s2_r[2] :
    (ctrl_r[C_SRC_NEXT] ? s2_r[1] : s2_r[0]);

  logic trig_act_w;
  assign trig_act_w = int_trig_i | trig_in_w;

  logic [31:0] addr_w;
  logic arb_sync_w;
  logic wave_sync_w;
  assign addr_w = ph_w >> (6'd32 - {1'b0, pts_r});
  assign arb_sync_w = (pts_r != 5'h00) && (addr_w < ARB_SYNC_PTS);
  assign wave_sync_w = arb_act_r ? arb_sync_w : ~ph_w[31];

  logic burst_done_w;
  assign burst_done_w = ~(burst_mode_i & burst_active_i);

  logic tout_w;
  assign tout_w = tout_pick(tout_act_r,
    {burst_done_w, ~seq_last_i, marker_i, wrap_r});

  logic tout_r;
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      tout_r <= 1'b0;
      trig_to_next_o <= 1'b0;
      trig_to_prev_o <= 1'b0;
      loop_trig_o <= 1'b0;
    end
    else
    begin
      tout_r <= tout_w;
      trig_to_next_o <= tout_w & ~ctrl_r[C_SRC_NEXT];
      trig_to_prev_o <= tout_w & ctrl_r[C_SRC_NEXT];
      loop_trig_o <= tout_w & ctrl_r[C_LOOP_END];
    end
  end

  // ----------------------------------------
  // Sweep sync
  // ----------------------------------------
  logic sweep_r;
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      sweep_r <= 1'b0;
    else if (sweep_start_i)
      sweep_r <= 1'b1;
    else if (sweep_step_i)
      sweep_r <= 1'b0;
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      sweep_mark_o <= 1'b0;
    else
      sweep_mark_o <= ctrl_r[C_MARK_EN] & sweep_step_i
        & (sweep_idx_i == swmk_r);
  end

  // ----------------------------------------
  // Sync output
  // ----------------------------------------
  logic sync_w;
  always_comb
  begin
    case (sync_act_r)
      S_WAVE: sync_w = wave_sync_w;
      S_MARK: sync_w = marker_i;
      S_BURST: sync_w = burst_done_w;
      S_SEQ: sync_w = ~seq_last_i;
      S_TRIG: sync_w = trig_act_w;
      S_SWEEP: sync_w = sweep_r | sweep_start_i;
      S_LOCK: sync_w = wrap_r;
      default: sync_w = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      sync_o <= 1'b0;
    else
      sync_o <= sync_w;
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rd_data_o <= 32'h0000_0000;
    else if (rd_i)
    begin
      case (addr_i)
        A_CTRL: rd_data_o <= {19'h0_0000, ctrl_r};
        A_PHASE: rd_data_o <= {20'h0_0000, phase_r};
        A_FREQ: rd_data_o <= freq_r;
        A_PTS: rd_data_o <= {27'h000_0000, pts_r};
        A_SWMK: rd_data_o <= {20'h0_0000, swmk_r};
        A_STAT: rd_data_o <= {27'h000_0000, sweep_r, trig_in_w, tout_r, sync_o, wrap_r};
        default: rd_data_o <= 32'h0000_0000;
      endcase
    end
    else
      rd_data_o <= 32'h0000_0000;
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  chain_dir_a: assert property (
    1'b1 |=> !(trig_to_next_o && trig_to_prev_o))
    else $error("trigger driven both ways");

  loop_gate_a: assert property (
    !ctrl_r[C_LOOP_END] |=> !loop_trig_o)
    else $error("loop driven while not end channel");

  slave_freq_a: assert property (
    ctrl_r[C_SLAVE] |-> freq_o == master_freq_i)
    else $error("slave ignores master frequency");

  wave_sync_a: assert property (
    sync_act_r == S_WAVE && !arb_act_r |=> sync_o == !$past(ph_w[31]))
    else $error("waveform sync not at phase half");

  burst_low_a: assert property (
    sync_act_r == S_BURST && burst_mode_i && burst_active_i |=> !sync_o)
    else $error("burst done high while active");

  seq_sync_a: assert property (
    sync_act_r == S_SEQ |=> sync_o == !$past(seq_last_i))
    else $error("sequence sync wrong level");

  sweep_hold_a: assert property (
    sweep_start_i ##1 (!sweep_step_i && !sweep_start_i) |-> sweep_r)
    else $error("sweep sync dropped before first step");

  sel_stable_a: assert property (
    !tick_w |=> $stable(sync_act_r) && $stable(tout_act_r))
    else $error("selection changed off tick");

endmodule
`default_nettype wire

// ==== common/cstr_pkg.sv ====
package cstr_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [3:0] A_CTRL = 4'h0;
  localparam logic [3:0] A_PHASE = 4'h1;
  localparam logic [3:0] A_FREQ = 4'h2;
  localparam logic [3:0] A_PTS = 4'h3;
  localparam logic [3:0] A_SWMK = 4'h4;
  localparam logic [3:0] A_STAT = 4'h5;
  // ----------------------------------------
  // Control fields
  // ----------------------------------------
  localparam int C_SRC_NEXT = 0;
  localparam int C_LOOP_END = 1;
  localparam int C_LOOP_START = 2;
  localparam int C_TOUT_LO = 3;
  localparam int C_SYNC_LO = 5;
  localparam int C_SLAVE = 8;
  localparam int C_CLK_LO = 9;
  localparam int C_ARB = 11;
  localparam int C_MARK_EN = 12;
  localparam int C_WIDTH = 13;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [12:0] CTRL_RST = 13'h0000;
  localparam logic [11:0] PHASE_RST = 12'h000;
  localparam logic [31:0] FREQ_RST = 32'h0000_0000;
  localparam logic [4:0] PTS_RST = 5'h0c;
  localparam logic [11:0] SWMK_RST = 12'h000;
  // ----------------------------------------
  // Source codes
  // ----------------------------------------
  localparam logic [1:0] T_WEND = 2'h0;
  localparam logic [1:0] T_MARK = 2'h1;
  localparam logic [1:0] T_SEQ = 2'h2;
  localparam logic [1:0] T_BURST = 2'h3;
  localparam logic [2:0] S_WAVE = 3'h0;
  localparam logic [2:0] S_MARK = 3'h1;
  localparam logic [2:0] S_BURST = 3'h2;
  localparam logic [2:0] S_SEQ = 3'h3;
  localparam logic [2:0] S_TRIG = 3'h4;
  localparam logic [2:0] S_SWEEP = 3'h5;
  localparam logic [2:0] S_LOCK = 3'h6;
  localparam logic [1:0] K_MASTER = 2'h0;
  localparam logic [1:0] K_SYS = 2'h1;
  localparam logic [1:0] K_EXT = 2'h2;
  // ----------------------------------------
  // Phase and sample constants
  // ----------------------------------------
  // Phase word per 0.1 degree: 2^32 / 3600
  localparam logic [31:0] PH_PER_TENTH = 32'h0012_3456;
  localparam logic [11:0] PH_TENTHS_FULL = 12'he10;
  localparam logic [4:0] PTS_FINE = 5'h0c;
  localparam logic [31:0] ARB_SYNC_PTS = 32'h0000_0004;
endpackage

// ==== testbench/cstr_partner.sv ====
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Neighbour channels and external clocks
// ----------------------------------------
module cstr_partner (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // Bench commands: loop, next, prev
  input wire logic [2:0] fire_i,
  // Pins and ticks
  output logic prev_trig_o,
  output logic next_trig_o,
  output logic loop_trig_o,
  output logic master_tick_o,
  output logic sys_tick_o,
  output logic ext_clk_o
);
  logic [1:0] cnt_r;
  // Pins are asynchronous, so skew them well off the clock edge
  initial {loop_trig_o, next_trig_o, prev_trig_o} = 3'h0;
  always @(fire_i) #7 {loop_trig_o, next_trig_o, prev_trig_o} = fire_i;
  // Arb clock runs free, unrelated in phase to the sample clock
  initial ext_clk_o = 1'b0;
  always #37 ext_clk_o = ~ext_clk_o;
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      cnt_r <= 2'h0;
    else
      cnt_r <= cnt_r + 2'h1;
  end
  // Master ticks every other cycle, system every fourth
  assign master_tick_o = cnt_r[0];
  assign sys_tick_o = (cnt_r == 2'h3);
endmodule
`default_nettype wire

// ==== testbench/testbench.sv ====
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import cstr_pkg::*;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [3:0] addr_i = 4'h0;
  logic [31:0] wr_data_i = 32'h0000_0000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [31:0] rd_data_o, freq_o, phase_o, rd_v, rv;
  logic [31:0] master_freq_i = 32'h0000_0000;
  logic [31:0] seed = 32'h0000_87f2;
  logic prev_trig_i, next_trig_i, loop_trig_i, master_tick_i, sys_tick_i, ext_clk_i;
  logic trig_to_next_o, trig_to_prev_o, loop_trig_o, sync_o, sweep_mark_o;
  logic [1:0] clk_sel_o;
  logic [2:0] fire = 3'h0;
  logic marker_i = 1'b0, seq_last_i = 1'b0, burst_mode_i = 1'b0, burst_active_i = 1'b0;
  logic int_trig_i = 1'b0, sweep_start_i = 1'b0, sweep_step_i = 1'b0;
  logic [11:0] sweep_idx_i = 12'h000;
  int n_fail = 0;
  int tests_run = 0;
  int idx[7] = '{0, 1, 2, 3, 4, 6, 15};
  always #50 sys_clk_i = ~sys_clk_i;
  cstr_router i_dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
    .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o),
    .prev_trig_i(prev_trig_i), .next_trig_i(next_trig_i), .loop_trig_i(loop_trig_i),
    .trig_to_next_o(trig_to_next_o), .trig_to_prev_o(trig_to_prev_o),
    .loop_trig_o(loop_trig_o), .master_tick_i(master_tick_i), .sys_tick_i(sys_tick_i),
    .ext_clk_i(ext_clk_i), .clk_sel_o(clk_sel_o), .master_freq_i(master_freq_i),
    .freq_o(freq_o), .phase_o(phase_o), .marker_i(marker_i), .seq_last_i(seq_last_i),
    .burst_mode_i(burst_mode_i), .burst_active_i(burst_active_i), .int_trig_i(int_trig_i),
    .sweep_start_i(sweep_start_i), .sweep_step_i(sweep_step_i),
    .sweep_idx_i(sweep_idx_i), .sync_o(sync_o), .sweep_mark_o(sweep_mark_o));
  cstr_partner i_far (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .fire_i(fire),
    .prev_trig_o(prev_trig_i), .next_trig_o(next_trig_i), .loop_trig_o(loop_trig_i),
    .master_tick_o(master_tick_i), .sys_tick_o(sys_tick_i), .ext_clk_o(ext_clk_i));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  function automatic logic [31:0] cw(input logic [2:0] ss, input logic [1:0] ts, input int f);
    return f | (32'(ss) << C_SYNC_LO) | (32'(ts) << C_TOUT_LO);
  endfunction
  function automatic logic pick(input int k);
    case (k)
      0: return sync_o;
      1: return trig_to_next_o;
      2: return trig_to_prev_o;
      3: return loop_trig_o;
      default: return sweep_mark_o;
    endcase
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    tests_run++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    addr_i <= a;
    wr_data_i <= d;
    wr_i <= 1'b1;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge sys_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    @(negedge sys_clk_i);
    rd_v = rd_data_o;
  endtask
  // Bounded wait: selections only land on a sample tick
  // Ends on a rising edge so the next stimulus is edge aligned
  task automatic wait_lvl(input int k, input logic v, input string m);
    int i;
    i = 0;
    @(negedge sys_clk_i);
    while (pick(k) !== v && i < 20)
    begin
      @(negedge sys_clk_i);
      i++;
    end
    chk({31'h0000_0000, pick(k)}, {31'h0000_0000, v}, m);
    @(posedge sys_clk_i);
  endtask
  task automatic hold_lvl(input int k, input logic v, input string m);
    logic bad;
    bad = 1'b0;
    repeat (8)
    begin
      @(negedge sys_clk_i);
      bad = bad | (pick(k) !== v);
    end
    chk({31'h0000_0000, bad}, 32'h0000_0000, m);
    @(posedge sys_clk_i);
  endtask
  // New selection reaches the pins before stimulus starts
  task automatic settle();
    repeat (4) @(posedge sys_clk_i);
  endtask
  task automatic close_out();
    $display("tests_run %0d n_fail %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    #(20000 * 100);
    n_fail++;
    close_out();
  end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial
  begin
    repeat (6) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    foreach (idx[j])
    begin
      rd(idx[j][3:0]);
      chk(rd_v, (idx[j] == 3) ? {27'h000_0000, PTS_RST} : 32'h0000_0000, "reset value");
    end
    $display("test registers done");
    wr(A_PHASE, 32'h0000_0e0f);
    rd(A_PHASE);
    chk(rd_v, 32'h0000_0e0f, "phase 3599");
    wr(A_PHASE, 32'h0000_0e10);
    rd(A_PHASE);
    chk(rd_v, 32'h0000_0e0f, "phase 3600 kept out");
    chk(phase_o, 32'h0000_0e0f * PH_PER_TENTH, "offset word");
    wr(A_PTS, 32'h0000_0004);
    wr(A_CTRL, 32'(1) << C_ARB);
    @(negedge sys_clk_i);
    chk(phase_o, 32'hf000_0000, "offset one point");
    wr(A_CTRL, 32'h0000_0000);
    @(negedge sys_clk_i);
    chk(phase_o, 32'h0000_0e0f * PH_PER_TENTH, "standard full offset");
    wr(A_PTS, {27'h000_0000, PTS_RST});
    repeat (3)
    begin
      seed = xs(seed);
      rv = seed;
      wr(A_FREQ, rv);
      rd(A_FREQ);
      chk(rd_v, rv, "freq readback");
      chk(freq_o, rv, "own freq");
    end
    wr(A_CTRL, 32'h0000_0100);
    repeat (2)
    begin
      @(posedge sys_clk_i);
      seed = xs(seed);
      master_freq_i <= seed;
      repeat (2) @(negedge sys_clk_i);
      chk(freq_o, seed, "slave follows");
    end
    for (int k = 0; k < 3; k++)
    begin
      wr(A_CTRL, 32'(k) << C_CLK_LO);
      @(negedge sys_clk_i);
      chk({30'h0000_0000, clk_sel_o}, 32'(k), "clock source");
    end
    $display("test lock done");
    wr(A_CTRL, cw(S_TRIG, T_WEND, 0));
    settle();
    fire <= 3'h1;
    wait_lvl(0, 1'b1, "prev trigger");
    fire <= 3'h2;
    wait_lvl(0, 1'b0, "prev released");
    hold_lvl(0, 1'b0, "next ignored");
    wr(A_CTRL, cw(S_TRIG, T_WEND, 1));
    settle();
    wait_lvl(0, 1'b1, "next trigger");
    fire <= 3'h4;
    wait_lvl(0, 1'b0, "loop unused");
    wr(A_CTRL, cw(S_TRIG, T_WEND, 4));
    settle();
    wait_lvl(0, 1'b1, "loop start");
    fire <= 3'h0;
    wait_lvl(0, 1'b0, "loop released");
    int_trig_i <= 1'b1;
    wait_lvl(0, 1'b1, "internal trigger");
    int_trig_i <= 1'b0;
    wr(A_CTRL, cw(S_MARK, T_MARK, 32'h0000_0800));
    settle();
    marker_i <= 1'b1;
    wait_lvl(1, 1'b1, "tout to next");
    hold_lvl(2, 1'b0, "tout not to prev");
    wr(A_CTRL, cw(S_MARK, T_MARK, 32'h0000_0803));
    settle();
    wait_lvl(2, 1'b1, "tout to prev");
    wait_lvl(3, 1'b1, "loop end");
    repeat (6)
    begin
      seed = xs(seed);
      marker_i <= seed[0];
      wait_lvl(0, seed[0], "marker sync");
    end
    $display("test routing done");
    wr(A_CTRL, cw(S_BURST, T_WEND, 0));
    settle();
    burst_mode_i <= 1'b1;
    burst_active_i <= 1'b1;
    wait_lvl(0, 1'b0, "burst active");
    burst_active_i <= 1'b0;
    wait_lvl(0, 1'b1, "burst idle");
    wr(A_CTRL, cw(S_SEQ, T_WEND, 0));
    settle();
    seq_last_i <= 1'b1;
    wait_lvl(0, 1'b0, "sequence last");
    seq_last_i <= 1'b0;
    wait_lvl(0, 1'b1, "sequence other");
    seed = xs(seed);
    wr(A_SWMK, {20'h0_0000, seed[11:0]});
    sweep_idx_i <= seed[11:0];
    wr(A_CTRL, cw(S_SWEEP, T_WEND, 32'h0000_1000));
    settle();
    sweep_start_i <= 1'b1;
    @(posedge sys_clk_i);
    sweep_start_i <= 1'b0;
    wait_lvl(0, 1'b1, "sweep start");
    hold_lvl(0, 1'b1, "first step");
    sweep_step_i <= 1'b1;
    @(posedge sys_clk_i);
    sweep_step_i <= 1'b0;
    wait_lvl(4, 1'b1, "sweep marker");
    wait_lvl(0, 1'b0, "second step");
    wait_lvl(4, 1'b0, "marker ends");
    wr(A_FREQ, 32'h2000_0000);
    wr(A_CTRL, cw(S_WAVE, T_WEND, 0));
    settle();
    wait_lvl(0, 1'b0, "wave low half");
    wait_lvl(0, 1'b1, "wave high half");
    wr(A_CTRL, cw(S_LOCK, T_WEND, 0));
    settle();
    wait_lvl(0, 1'b1, "lock edge");
    wait_lvl(0, 1'b0, "lock ends");
    // Sixteen points: first four addresses span two ticks
    wr(A_PTS, 32'h0000_0004);
    wr(A_CTRL, cw(S_WAVE, T_WEND, 32'h0000_0800));
    settle();
    wait_lvl(0, 1'b1, "arb first points");
    repeat (4) @(negedge sys_clk_i);
    chk({31'h0000_0000, sync_o}, 32'h0000_0000, "arb pulse ends");
    $display("test sync done");
    close_out();
  end
endmodule
`default_nettype wire
